// ==== testbench/csr_host_model.sv ====
// Host model: issues single-byte register writes to the command byte it is given.
// Assumes callers run on ref_clk falling edges.
`timescale 1ns/100ps
module csr_host_model
(
   input wire logic ref_clk, // Bench clock
   output logic [7:0] reg_addr, // Command byte
   output logic reg_wr, // Write strobe
   output logic [7:0] reg_wdata // Write data
);
   initial {reg_addr, reg_wr, reg_wdata} = 17'h0;
   // One-cycle write; idle lines are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask : wr
endmodule : csr_host_model

// ==== testbench/testbench.sv ====
// Testbench: drives pins, events and host writes; checks read image and interrupt.
// Assumes csr_pkg, the design and the host model are compiled first.
`timescale 1ns/100ps
module testbench
   import csr_pkg::*;
;
   logic ref_clk = 0, rst_n = 0, chk = 0; // Clock, reset, check request
   logic gpa = 0, gpb = 0, lock = 0, ma = 0, mb = 0, ot = 0; // Pins and events
   logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register bus
   logic reg_wr, irq_n, ara_respond; // Strobe and outputs
   logic [8:0] q[$]; // Expected {irq_n, image}
   int err_count = 0, compares = 0, cyc = 0; // Counters
   csr_common_status u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .slot_a_gp_pin(gpa),
      .slot_b_gp_pin(gpb), .supply_low_lockout(lock), .slot_a_main_on(ma),
      .slot_b_main_on(mb), .overtemp_event(ot), .irq_n(irq_n), .ara_respond(ara_respond));
   csr_host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata));
   initial forever #2.5 ref_clk = ~ref_clk;
   // ****************************************
   // Checking
   // ****************************************
   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string nm);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   // Monitor: takes oldest note when a check is due; watchdog
   always @(posedge ref_clk)
   begin
      cyc++;
      if (chk) check({irq_n, reg_rdata}, q.pop_front(), "image");
      if (rst_n) check({8'h00, ara_respond}, 9'h000, "ara");
      if (cyc == 3000)
      begin
         err_count++;
         conclude();
      end
   end
   // ****************************************
   // Stimulus
   // ****************************************
   task automatic ck(input logic irq, input logic [7:0] f);
      q.push_back({irq, 2'b00, gpb, gpa, f[3:0]});
      @(negedge ref_clk) chk = 1;
      @(negedge ref_clk) chk = 0;
   endtask : ck
   // One-cycle lockout and/or overtemp event
   task automatic ev(input logic l, input logic o);
      @(negedge ref_clk) {lock, ot} = {l, o};
      @(negedge ref_clk) {lock, ot} = 2'b00;
   endtask : ev
   initial
   begin
      void'($urandom(32'h1264));
      repeat (12) @(negedge ref_clk);
      rst_n = 1;
      ck(1, 8'h00);
      // Random pin levels, waited past the synchroniser
      repeat (4)
      begin
         {gpb, gpa} = 2'($urandom);
         repeat (8) @(negedge ref_clk);
         ck(1, 8'h00);
      end
      // Fixed levels so both follow checks see their case
      for (int i = 1; i < 3; i++)
      begin
         {gpb, gpa} = 2'(i);
         repeat (8) @(negedge ref_clk);
         ck(1, 8'h00);
      end
      ev(0, 1);
      ck(0, 8'h02);
      u_host.wr(8'h06, 8'hf8); // Mask on, upper bits ignored
      ck(1, 8'h0a);
      u_host.wr(8'h05, 8'hff); // Other address ignored
      ck(1, 8'h0a);
      u_host.wr(8'h06, 8'h00);
      ck(0, 8'h02);
      u_host.wr(8'h06, 8'h02); // Clear releases interrupt
      ck(1, 8'h00);
      // Event and clear in one cycle: the event wins
      fork
         u_host.wr(8'h06, 8'h02);
         ev(0, 1);
      join
      ck(0, 8'h02);
      u_host.wr(8'h06, 8'h02);
      ck(1, 8'h00);
      ev(1, 0); // Lockout with no slot powered
      ck(1, 8'h00);
      ma = 1;
      ev(1, 0); // Slot A powered alone qualifies
      ck(0, 8'h04);
      u_host.wr(8'h06, 8'h04);
      ck(1, 8'h00);
      {ma, mb} = 2'b01;
      ev(1, 1);
      ck(0, 8'h06);
      u_host.wr(8'h06, 8'h06);
      ck(1, 8'h00);
      // Mid-run reset drops a pending fault and the interrupt
      ev(0, 1);
      @(negedge ref_clk);
      rst_n = 0;
      repeat (3) @(negedge ref_clk);
      rst_n = 1;
      repeat (8) @(negedge ref_clk); // Pins resynchronise after reset
      ck(1, 8'h00);
      conclude();
   end
endmodule : testbench

// ==== verilog/csr_common_status.sv ====
// Common status register: live GP inputs, interrupt mask, sticky fault flags.
// Assumes an SMBus slave front end on ref_clk supplies decoded write/read strobes.
`timescale 1ns/100ps
// Operation
// - Bit 5 shows live slot B input
// - Bit 4 shows live slot A input
// - Mask 0 enables, 1 suppresses interrupt
// - No alert response address participation
// - Bit 2 set on lockout breaker trip
// - Lockout counts only while slot powered
// - Bit 1 set on die overtemperature
// - Faults stay set until one written
// - Clearing fault releases interrupt output
module csr_common_status
   import csr_pkg::*;
(
   input wire logic ref_clk,            // 200 MHz clock
   input wire logic rst_n,              // Async reset, active low
   input wire logic [7:0] reg_addr,     // Command byte from bus front end
   input wire logic reg_wr,             // Write strobe, one cycle
   input wire logic [7:0] reg_wdata,    // Write data
   output logic [7:0] reg_rdata,        // Read data, registered
   input wire logic slot_a_gp_pin,      // Asynchronous pin
   input wire logic slot_b_gp_pin,      // Asynchronous pin
   input wire logic supply_low_lockout, // Lockout trip event, same clock
   input wire logic slot_a_main_on,     // Slot A main enable pin or control bit
   input wire logic slot_b_main_on,     // Slot B main enable pin or control bit
   input wire logic overtemp_event,     // Die above 160 C, same clock
   output logic irq_n,                  // Interrupt, active low
   output logic ara_respond             // Alert response participation, always 0
);
   // ****************************************
   // State
   // ****************************************
   logic [2:0] sync_a_q, sync_a_d;      // GP A synchroniser
   logic [2:0] sync_b_q, sync_b_d;      // GP B synchroniser
   logic slot_a_gp_input_q, slot_a_gp_input_d; // Filtered level
   logic slot_b_gp_input_q, slot_b_gp_input_d; // Filtered level
   logic irq_mask_q, irq_mask_d;        // Interrupt mask bit
   logic undervoltage_flag_q, undervoltage_flag_d; // Sticky lockout fault
   logic overtemp_flag_q, overtemp_flag_d; // Sticky die heat fault
   logic irq_n_q, irq_n_d;              // Interrupt, active low
   logic [7:0] rdata_q, rdata_d;        // Read image
   logic wr_hit;                        // Write to this register
   logic uv_trip;                       // Lockout while a slot is powered

   // ****************************************
   // Build checks
   // ****************************************
   // The filter below reads stages two and three of exactly three
   if (CSR_SYNC_STAGES != 3)
   begin : g_sync_depth
      $error("pin synchroniser must have three stages");
   end

   // ****************************************
   // Helpers
   // ****************************************
   // Lockout only counts while either slot has main power
   function automatic logic csr_uv_qualify
   (
      input logic lockout,
      input logic a_on,
      input logic b_on
   );
      return lockout && (a_on || b_on);
   endfunction : csr_uv_qualify

   // Filter step: level moves only once stages two and three agree
   function automatic logic csr_gp_filter
   (
      input logic [2:0] stages,
      input logic level
   );
      return (stages[1] == stages[2]) ? stages[2] : level;
   endfunction : csr_gp_filter

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Shift both pins in; only stage two reads stage one
   always_comb
   begin
      sync_a_d = {sync_a_q[1:0], slot_a_gp_pin};
      sync_b_d = {sync_b_q[1:0], slot_b_gp_pin};
      slot_a_gp_input_d = csr_gp_filter(sync_a_q, slot_a_gp_input_q);
      slot_b_gp_input_d = csr_gp_filter(sync_b_q, slot_b_gp_input_q);
   end

   // Synchroniser and filtered level registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_a_q <= 3'h0;
         sync_b_q <= 3'h0;
         slot_a_gp_input_q <= 1'b0;     // Pins read low until resampled
         slot_b_gp_input_q <= 1'b0;
      end
      else
      begin
         sync_a_q <= sync_a_d;
         sync_b_q <= sync_b_d;
         slot_a_gp_input_q <= slot_a_gp_input_d;
         slot_b_gp_input_q <= slot_b_gp_input_d;
      end
   end

   // ****************************************
   // Write decode and interrupt mask
   // ****************************************
   // Only writes to this command byte touch the mask
   always_comb
   begin
      wr_hit = reg_wr && (reg_addr == CSR_STATUS_OFFSET);
      irq_mask_d = irq_mask_q;
      if (wr_hit)
         irq_mask_d = reg_wdata[CSR_BIT_MASK];
   end

   // Mask register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_mask_q <= CSR_STATUS_RESET[CSR_BIT_MASK];
      end
      else
      begin
         irq_mask_q <= irq_mask_d;
      end
   end

   // ****************************************
   // Sticky fault flags
   // ****************************************
   // Write one clears; a new event in the same cycle wins
   always_comb
   begin
      uv_trip = csr_uv_qualify(supply_low_lockout, slot_a_main_on, slot_b_main_on);
      undervoltage_flag_d = undervoltage_flag_q;
      if (wr_hit && reg_wdata[CSR_BIT_UV])
         undervoltage_flag_d = 1'b0;    // Host clear
      // Set after clear so the event is never lost
      if (uv_trip)
         undervoltage_flag_d = 1'b1;
      overtemp_flag_d = overtemp_flag_q;
      if (wr_hit && reg_wdata[CSR_BIT_OT])
         overtemp_flag_d = 1'b0;        // Host clear
      // Same ordering for the heat fault
      if (overtemp_event)
         overtemp_flag_d = 1'b1;
   end

   // Fault flag registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         undervoltage_flag_q <= CSR_STATUS_RESET[CSR_BIT_UV];
         overtemp_flag_q <= CSR_STATUS_RESET[CSR_BIT_OT];
      end
      else
      begin
         undervoltage_flag_q <= undervoltage_flag_d;
         overtemp_flag_q <= overtemp_flag_d;
      end
   end

   // ****************************************
   // Interrupt output
   // ****************************************
   // Low while any fault pends and unmasked; follows next values
   always_comb
   begin
      irq_n_d = ~((undervoltage_flag_d || overtemp_flag_d) && !irq_mask_d);
   end

   // Interrupt register, idle high
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_n_q <= 1'b1;
      end
      else
      begin
         irq_n_q <= irq_n_d;
      end
   end

   // ****************************************
   // Read image
   // ****************************************
   // Assemble the byte; reserved bits stay zero
   always_comb
   begin
      rdata_d = 8'h00;                  // Bits 7:6 and 0 read zero
      rdata_d[CSR_BIT_GP_B] = slot_b_gp_input_q;
      rdata_d[CSR_BIT_GP_A] = slot_a_gp_input_q;
      rdata_d[CSR_BIT_MASK] = irq_mask_q;
      rdata_d[CSR_BIT_UV] = undervoltage_flag_q;
      rdata_d[CSR_BIT_OT] = overtemp_flag_q;
   end

   // Read image register, one cycle behind the state
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= CSR_STATUS_RESET;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign reg_rdata = rdata_q;
   assign irq_n = irq_n_q;
   // Alert response is never joined, so this stays low
   assign ara_respond = 1'b0;

   // ****************************************
   // Checks
   // ****************************************
   a_uv_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      supply_low_lockout && (slot_a_main_on || slot_b_main_on) |=> undervoltage_flag_q)
      else $error("undervoltage flag not set");
   a_uv_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !undervoltage_flag_q && !(supply_low_lockout && (slot_a_main_on || slot_b_main_on))
      |=> !undervoltage_flag_q)
      else $error("undervoltage flag set without cause");
   a_ot_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overtemp_event |=> overtemp_flag_q)
      else $error("overtemp flag not set");
   a_ot_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !overtemp_flag_q && !overtemp_event |=> !overtemp_flag_q)
      else $error("overtemp flag set without cause");
   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      overtemp_flag_q && !(wr_hit && reg_wdata[CSR_BIT_OT]) |=> overtemp_flag_q)
      else $error("overtemp flag dropped");
   a_uv_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      undervoltage_flag_q && !(wr_hit && reg_wdata[CSR_BIT_UV]) |=> undervoltage_flag_q)
      else $error("undervoltage flag dropped");
   a_irq_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_hit && reg_wdata[CSR_BIT_UV] && reg_wdata[CSR_BIT_OT] && !supply_low_lockout
      && !overtemp_event |=> irq_n)
      else $error("interrupt not released");
   a_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq_mask_q |-> irq_n)
      else $error("masked interrupt asserted");
   a_mask_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_hit && reg_wdata[CSR_BIT_MASK] |=> irq_mask_q)
      else $error("mask write not taken");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !irq_n |-> (undervoltage_flag_q || overtemp_flag_q) && !irq_mask_q)
      else $error("interrupt without fault");
   a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rdata[7:6] == 2'b00 && !reg_rdata[0])
      else $error("reserved bits nonzero");
   a_gp_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (slot_b_gp_pin == 1'b1) [*4] |=> ##1 reg_rdata[CSR_BIT_GP_B])
      else $error("slot B input not shown");
   a_gp_a_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (slot_a_gp_pin == 1'b0) [*4] |=> ##1 !reg_rdata[CSR_BIT_GP_A])
      else $error("slot A input not shown");
   a_no_ara: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !ara_respond)
      else $error("alert response driven");
endmodule : csr_common_status

// ==== verilog/csr_pkg.sv ====
// Constants for the common status register bank.
// Assumes a single ref_clk domain and an SMBus front end that decodes register offsets.
package csr_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CSR_STATUS_OFFSET = 8'h06; // Command byte of the register
   localparam logic [7:0] CSR_STATUS_RESET = 8'h00;  // Power-up value
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CSR_BIT_GP_B = 5;      // Slot B general input
   localparam int CSR_BIT_GP_A = 4;      // Slot A general input
   localparam int CSR_BIT_MASK = 3;      // Interrupt mask
   localparam int CSR_BIT_UV = 2;        // Undervoltage flag
   localparam int CSR_BIT_OT = 1;        // Overtemperature flag
   localparam int CSR_SYNC_STAGES = 3;   // Pin synchroniser depth
endpackage : csr_pkg
